// >>> design/dprs_alu.sv
// Purpose: Sixteen-bit ALU with sixteen logic and sixteen arithmetic functions.
// Assumes: Operands and result use positive polarity at these ports.
// Notes:   Purely combinational.
`timescale 1ns/100ps
module dprs_alu
  import dprs_pkg::*;
#(
  parameter int unsigned W = WORD_W
) (
  input  wire logic [W-1:0] a_word,
  input  wire logic [W-1:0] b_word,
  input  wire logic [3:0]   func_sel,
  input  wire logic         logic_mode,
  input  wire logic         carry_in,
  output logic      [W-1:0] result,
  output logic              carry_out
);

  logic [W:0]   sum;
  logic [W-1:0] lg;

  // [RULE1] Logic function table.
  always_comb begin
    case (func_sel)
      4'h0:    lg = ~a_word;
      4'h1:    lg = ~(a_word | b_word);
      4'h2:    lg = ~a_word & b_word;
      4'h3:    lg = '0;
      4'h4:    lg = ~(a_word & b_word);
      4'h5:    lg = ~b_word;
      4'h6:    lg = a_word ^ b_word;
      4'h7:    lg = a_word & ~b_word;
      4'h8:    lg = ~a_word | b_word;
      4'h9:    lg = ~(a_word ^ b_word);
      4'hA:    lg = b_word;
      4'hB:    lg = a_word & b_word;
      4'hC:    lg = '1;
      4'hD:    lg = a_word | ~b_word;
      4'hE:    lg = a_word | b_word;
      default: lg = a_word;
    endcase
  end

  // [RULE1] Arithmetic function table.
  always_comb begin
    case (func_sel)
      4'h0:    sum = {1'b0, a_word} + W'(carry_in);
      4'h1:    sum = {1'b0, a_word | b_word} + W'(carry_in);
      4'h2:    sum = {1'b0, a_word | ~b_word} + W'(carry_in);
      4'h3:    sum = {1'b0, {W{1'b1}}} + W'(carry_in);
      4'h4:    sum = {1'b0, a_word} + {1'b0, a_word & ~b_word}
                     + W'(carry_in);
      4'h5:    sum = {1'b0, a_word | b_word} + {1'b0, a_word & ~b_word}
                     + W'(carry_in);
      4'h6:    sum = {1'b0, a_word} + {1'b0, ~b_word} + W'(carry_in);
      4'h7:    sum = {1'b0, a_word & ~b_word} + {1'b0, {W{1'b1}}}
                     + W'(carry_in);
      4'h8:    sum = {1'b0, a_word} + {1'b0, a_word & b_word}
                     + W'(carry_in);
      4'h9:    sum = {1'b0, a_word} + {1'b0, b_word} + W'(carry_in);
      4'hA:    sum = {1'b0, a_word | ~b_word} + {1'b0, a_word & b_word}
                     + W'(carry_in);
      4'hB:    sum = {1'b0, a_word & b_word} + {1'b0, {W{1'b1}}}
                     + W'(carry_in);
      4'hC:    sum = {1'b0, a_word} + {1'b0, a_word} + W'(carry_in);
      4'hD:    sum = {1'b0, a_word | b_word} + {1'b0, a_word}
                     + W'(carry_in);
      4'hE:    sum = {1'b0, a_word | ~b_word} + {1'b0, a_word}
                     + W'(carry_in);
      default: sum = {1'b0, a_word} + {1'b0, {W{1'b1}}} + W'(carry_in);
    endcase
  end

  assign result    = logic_mode ? lg : sum[W-1:0];
  assign carry_out = logic_mode ? 1'b0 : sum[W];

endmodule

// >>> design/dprs_pkg.sv
// Purpose: Shared constants and types for the data path result and sequencer.
// Assumes: One processor clock, synchronous active-low reset.
// Notes:   Machine cycle is a count of clock cycles derived from its time.
package dprs_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned STEP_W       = 8;
  localparam int unsigned CS_ROMS      = 10;
  localparam int unsigned CS_ROM_W     = 4;
  localparam int unsigned CS_W         = CS_ROMS * CS_ROM_W;
  localparam int unsigned CS_DEPTH     = 256;
  localparam int unsigned RX_GROUP_W   = 4;
  localparam int unsigned PRIO_IN_W    = 5;
  localparam int unsigned PRIO_OUT_W   = 8;

  // ****************************************************************
  // Control store field positions
  // ****************************************************************
  localparam int unsigned NXT_LSB      = 0;
  localparam int unsigned ALU_SEL_LSB  = 8;
  localparam int unsigned ALU_MODE_BIT = 12;
  localparam int unsigned ALU_CIN_BIT  = 13;
  localparam int unsigned PATH_SEL_BIT = 14;
  localparam int unsigned IR_LOAD_BIT  = 15;
  localparam int unsigned BA_LOAD_BIT  = 16;
  localparam int unsigned BUS_DRV_BIT  = 17;
  localparam int unsigned BR_LOAD_BIT  = 18;
  localparam int unsigned SP_LOAD_BIT  = 19;
  localparam int unsigned PS_LOAD_BIT  = 20;
  localparam int unsigned SL_LOAD_BIT  = 21;
  localparam int unsigned LC_LOAD_BIT  = 22;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0]  START_STEP   = 8'h00;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CYCLE_NS      = 310;
  localparam int unsigned CYCLE_CLKS    =
    (CYCLE_NS / CLK_PERIOD_NS) < 1 ? 1 : (CYCLE_NS / CLK_PERIOD_NS);
  localparam logic [2:0]  CYCLE_LAST    = 3'(CYCLE_CLKS - 1);

  // ****************************************************************
  // Branch conditions
  // ****************************************************************
  typedef enum logic [3:0] {
    DPRS_BR_ALWAYS, DPRS_BR_NE, DPRS_BR_EQ, DPRS_BR_GE,
    DPRS_BR_LT, DPRS_BR_GT, DPRS_BR_LE, DPRS_BR_PL,
    DPRS_BR_MI, DPRS_BR_HI, DPRS_BR_LOS, DPRS_BR_VC,
    DPRS_BR_VS, DPRS_BR_CC, DPRS_BR_CS, DPRS_BR_NEVER
  } dprs_branch_t;

endpackage

// >>> design/dprs_top.sv
// What this block does
// [RULE1] The ALU performs sixteen logic and sixteen arithmetic functions on two 16-bit words.
// [RULE2] The result mux takes the ALU word first and the bus data word second.
// [RULE3] Bus data arrives through inverting receivers, one per 4-bit group.
// [RULE4] The mux inverts the ALU word and passes the bus word unchanged.
// [RULE5] A high path select gives the ALU word and a low one gives the bus word.
// [RULE6] The upper mux select is tied low so only the path select chooses.
// [RULE7] The mux output feeds address, bus drivers, IR, B, scratch pad, status, serial and clock.
// [RULE8] Data is active low on the bus and in the ALU region, active high elsewhere.
// [RULE9] A signal ending in _n counts as true when low.
// [RULE10] All actions run as microsteps from the control store, whose outputs steer the data path.
// [RULE11] The control store is ten 256 by 4 ROMs sharing one 8-bit address.
// [RULE12] The 8-bit microstep counter loads once per machine cycle of about 310 ns.
// [RULE13] The next address is the next-step field ORed with the microbranch bits.
// [RULE14] With several console switches pressed, exactly one function is chosen.
// [RULE15] The 5-input encoder gives one-hot highest input, any and multiple flags, spare zero.
// [RULE16] A branch decoder tests each branch condition against C, N, V and Z.
// [RULE17] Reset loads the microstep counter with a fixed start address.
//
// Purpose: Result mux, microstep sequencer, console encoder, branch decoder.
// Assumes: Control store contents are loaded through a write port.
// Notes:   The bus data input and bus drive output are active low.
`timescale 1ns/100ps
module dprs_top
  import dprs_pkg::*;
#(
  parameter int unsigned W     = WORD_W,
  parameter int unsigned SW    = STEP_W,
  parameter int unsigned DEPTH = CS_DEPTH
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [W-1:0]      bus_data_n,
  input  wire logic [W-1:0]      a_leg,
  input  wire logic [W-1:0]      b_leg,
  input  wire logic [SW-1:0]     branch_bits,
  input  wire logic [PRIO_IN_W-1:0] console_switch_n,
  input  wire logic [3:0]        branch_code,
  input  wire logic              flag_c,
  input  wire logic              flag_n,
  input  wire logic              flag_v,
  input  wire logic              flag_z,
  input  wire logic              cs_wr_en,
  input  wire logic [SW-1:0]     cs_wr_addr,
  input  wire logic [CS_W-1:0]   cs_wr_data,
  output logic      [W-1:0]      result_word_q,
  output logic      [W-1:0]      bus_addr_q,
  output logic      [W-1:0]      bus_drive_n_q,
  output logic      [W-1:0]      instr_q,
  output logic      [W-1:0]      b_reg_q,
  output logic      [W-1:0]      scratch_pad_q,
  output logic      [W-1:0]      status_word_q,
  output logic      [W-1:0]      serial_ctl_q,
  output logic      [W-1:0]      line_clock_q,
  output logic                   instr_reg_load_n,
  output logic      [SW-1:0]     microstep_counter_q,
  output logic      [CS_W-1:0]   cs_word_q,
  output logic      [PRIO_OUT_W-1:0] switch_pick_q,
  output logic                   branch_taken_q,
  output logic                   carry_q
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [PRIO_OUT_W-1:0] prio_encode(
    input logic [PRIO_IN_W-1:0] req
  );
    logic [PRIO_OUT_W-1:0] y;
    int unsigned           cnt;
    y   = '0;
    cnt = 0;
    for (int i = 0; i < PRIO_IN_W; i++) begin
      cnt = cnt + int'(req[i]);
    end
    for (int i = 0; i < PRIO_IN_W; i++) begin
      if (req[i]) begin
        y[PRIO_IN_W-1:0] = PRIO_IN_W'(1) << i;
      end
    end
    y[5] = (cnt != 0);
    y[6] = (cnt > 1);
    y[7] = 1'b0;
    return y;
  endfunction

  function automatic logic branch_eval(
    input logic [3:0] code,
    input logic       c,
    input logic       n,
    input logic       v,
    input logic       z
  );
    logic t;
    case (dprs_branch_t'(code))
      DPRS_BR_ALWAYS: t = 1'b1;
      DPRS_BR_NE:     t = ~z;
      DPRS_BR_EQ:     t = z;
      DPRS_BR_GE:     t = ~(n ^ v);
      DPRS_BR_LT:     t = n ^ v;
      DPRS_BR_GT:     t = ~(z | (n ^ v));
      DPRS_BR_LE:     t = z | (n ^ v);
      DPRS_BR_PL:     t = ~n;
      DPRS_BR_MI:     t = n;
      DPRS_BR_HI:     t = ~(c | z);
      DPRS_BR_LOS:    t = c | z;
      DPRS_BR_VC:     t = ~v;
      DPRS_BR_VS:     t = v;
      DPRS_BR_CC:     t = ~c;
      DPRS_BR_CS:     t = c;
      default:        t = 1'b0;
    endcase
    return t;
  endfunction

  // ****************************************************************
  // Control store and machine cycle
  // ****************************************************************
  // [RULE11] Ten 4-bit ROM slices held as one wide array.
  logic [CS_W-1:0] cs_mem [DEPTH];
  logic [2:0]      cyc_q;
  logic            step_end;
  logic [SW-1:0]   step_d;

  always_ff @(posedge mclk) begin
    if (cs_wr_en) begin
      cs_mem[cs_wr_addr] <= cs_wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cyc_q <= 3'h0;
    end else if (cyc_q == CYCLE_LAST) begin
      cyc_q <= 3'h0;
    end else begin
      cyc_q <= cyc_q + 3'h1;
    end
  end

  assign step_end = (cyc_q == CYCLE_LAST);

  // [RULE13] Next step ORed with the branch network.
  assign step_d = cs_word_q[NXT_LSB +: SW] | branch_bits;

  // [RULE12] Load once per machine cycle.
  // [RULE17] Reset loads start step.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      microstep_counter_q <= START_STEP;
    end else if (step_end) begin
      microstep_counter_q <= step_d;
    end
  end

  // [RULE10] Fetch the microword that steers the data path.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cs_word_q <= '0;
    end else if (cyc_q == 3'h0) begin
      cs_word_q <= cs_mem[microstep_counter_q];
    end
  end

  // ****************************************************************
  // ALU and result mux
  // ****************************************************************
  logic [W-1:0] alu_pos;
  logic [W-1:0] alu_neg;
  logic [W-1:0] bus_rx;
  logic [W-1:0] mux_a;
  logic [W-1:0] mux_out;
  logic         alu_cout;
  logic         mux_sel_low;
  logic         mux_sel_high;
  logic         result_path_select;

  dprs_alu #(
    .W (W)
  ) u_alu (
    .a_word     (a_leg),
    .b_word     (b_leg),
    .func_sel   (cs_word_q[ALU_SEL_LSB +: 4]),
    .logic_mode (cs_word_q[ALU_MODE_BIT]),
    .carry_in   (cs_word_q[ALU_CIN_BIT]),
    .result     (alu_pos),
    .carry_out  (alu_cout)
  );

  // [RULE8] ALU region carries negative polarity.
  assign alu_neg = ~alu_pos;

  // [RULE3] Inverting receivers per 4-bit group.
  always_comb begin
    for (int g = 0; g < W / RX_GROUP_W; g++) begin
      bus_rx[g*RX_GROUP_W +: RX_GROUP_W] =
        ~bus_data_n[g*RX_GROUP_W +: RX_GROUP_W];
    end
  end

  // [RULE4] Inverting A input turns the ALU word positive.
  assign mux_a = ~alu_neg;

  assign result_path_select = cs_word_q[PATH_SEL_BIT];
  assign mux_sel_low        = result_path_select;
  // [RULE6] Upper select tied low.
  assign mux_sel_high       = 1'b0;

  // [RULE2] Two-word mux selection.
  // [RULE5] High selects ALU, low selects bus.
  always_comb begin
    case ({mux_sel_high, mux_sel_low})
      2'b01:   mux_out = mux_a;
      2'b00:   mux_out = bus_rx;
      default: mux_out = bus_rx;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      result_word_q <= '0;
      carry_q       <= 1'b0;
    end else begin
      result_word_q <= mux_out;
      carry_q       <= alu_cout;
    end
  end

  // ****************************************************************
  // Destinations of the result word
  // ****************************************************************
  logic load_en;

  assign load_en = step_end;

  // [RULE9] Active-low load strobe for the instruction register.
  assign instr_reg_load_n = ~(load_en & cs_word_q[IR_LOAD_BIT]);

  // [RULE7] Each destination loads from the mux output.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_addr_q    <= '0;
      instr_q       <= '0;
      b_reg_q       <= '0;
      scratch_pad_q <= '0;
      status_word_q <= '0;
      serial_ctl_q  <= '0;
      line_clock_q  <= '0;
    end else if (load_en) begin
      if (cs_word_q[BA_LOAD_BIT]) begin
        bus_addr_q <= mux_out;
      end
      if (!instr_reg_load_n) begin
        instr_q <= mux_out;
      end
      if (cs_word_q[BR_LOAD_BIT]) begin
        b_reg_q <= mux_out;
      end
      if (cs_word_q[SP_LOAD_BIT]) begin
        scratch_pad_q <= mux_out;
      end
      if (cs_word_q[PS_LOAD_BIT]) begin
        status_word_q <= mux_out;
      end
      if (cs_word_q[SL_LOAD_BIT]) begin
        serial_ctl_q <= mux_out;
      end
      if (cs_word_q[LC_LOAD_BIT]) begin
        line_clock_q <= mux_out;
      end
    end
  end

  // [RULE8] Bus drivers send negative polarity; all ones is idle.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_drive_n_q <= '1;
    end else if (load_en) begin
      bus_drive_n_q <= cs_word_q[BUS_DRV_BIT] ? ~mux_out : '1;
    end
  end

  // ****************************************************************
  // Console priority encoder and branch decoder
  // ****************************************************************
  // [RULE14] One switch function is picked.
  // [RULE15] Highest input wins with flags and spare zero.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      switch_pick_q <= '0;
    end else begin
      switch_pick_q <= prio_encode(~console_switch_n);
    end
  end

  // [RULE16] Branch condition evaluation.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      branch_taken_q <= 1'b0;
    end else begin
      branch_taken_q <= branch_eval(branch_code, flag_c, flag_n,
                                    flag_v, flag_z);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_step_boundary;
    step_end && reset_n;
  endsequence

  a_step_load: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE13]
    s_step_boundary |=> microstep_counter_q == $past(step_d))
    else $error("microstep counter did not load next address");

  a_step_hold: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE12]
    !step_end |=> $stable(microstep_counter_q))
    else $error("microstep counter changed mid cycle");

  a_cycle_len: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE12]
    step_end |=> !step_end [*5] ##1 step_end)
    else $error("machine cycle length wrong");

  a_reset_start: assert property (@(posedge mclk) // [RULE17]
    !reset_n |=> microstep_counter_q == START_STEP)
    else $error("reset did not load start address");

  a_mux_alu: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
    result_path_select |=> result_word_q == $past(alu_pos))
    else $error("ALU word not selected");

  a_mux_bus: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE3]
    !result_path_select |=> result_word_q == ~$past(bus_data_n))
    else $error("bus word not selected");

  a_prio_onehot: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE15]
    ##1 ($countones(switch_pick_q[4:0]) == int'(switch_pick_q[5])
         && !switch_pick_q[7]))
    else $error("encoder output not one-hot");

  a_prio_top: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE14]
    !console_switch_n[4] |=> switch_pick_q[4:0] == 5'h10
                             && switch_pick_q[6] == ($past(~console_switch_n)
                                                     != 5'h10))
    else $error("highest switch not chosen");

  a_branch_eq: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE16]
    branch_code == 4'h2 |=> branch_taken_q == $past(flag_z))
    else $error("equal branch wrong");

  a_ir_strobe: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE9]
    !instr_reg_load_n |=> instr_q == $past(mux_out))
    else $error("instruction register not loaded");

endmodule

// >>> verification/dprs_far_model.sv
// Purpose: Far side model, bus data line drivers and console switches.
// Assumes: Inputs change at the rising clock edge.
// Notes:   A released bus floats high, which reads as logic zero.
`timescale 1ns/100ps
module dprs_far_model
  import dprs_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 bus_valid,
  input  wire logic [WORD_W-1:0]    bus_word,
  input  wire logic [PRIO_IN_W-1:0] sw_pressed,
  output logic      [WORD_W-1:0]    bus_data_n,
  output logic      [PRIO_IN_W-1:0] console_switch_n
);
  // ********************
  // Line drivers
  // ********************
  initial begin
    bus_data_n       = '1;
    console_switch_n = '1;
  end

  always @(posedge mclk) begin
    bus_data_n <= bus_valid ? ~bus_word : '1;
  end

  always @(posedge mclk) begin
    console_switch_n <= ~sw_pressed;
  end
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the result mux and sequencer.
// Assumes: Inputs driven at the rising edge, checks at the falling edge.
// Notes:   A small looping microprogram is written before the run.
`timescale 1ns/100ps
module tb_top
  import dprs_pkg::*;
;
  // ********************
  // Signals
  // ********************
  logic                    mclk = 1'b0;
  logic                    reset_n = 1'b0;
  logic [WORD_W-1:0]       a_leg = '0, b_leg = '0, bus_word = '0;
  logic                    bus_valid = 1'b0;
  logic [PRIO_IN_W-1:0]    sw_pressed = '0;
  logic [WORD_W-1:0]       bus_data_n;
  logic [PRIO_IN_W-1:0]    console_switch_n;
  logic [STEP_W-1:0]       branch_bits = '0, cs_wr_addr = '0;
  logic [3:0]              branch_code = '0;
  logic                    flag_c = 0, flag_n = 0, flag_v = 0, flag_z = 0;
  logic                    cs_wr_en = 1'b0;
  logic [CS_W-1:0]         cs_wr_data = '0, cs_word_q;
  logic [WORD_W-1:0]       result_word_q, bus_addr_q, bus_drive_n_q;
  logic [WORD_W-1:0]       instr_q, b_reg_q, scratch_pad_q;
  logic [WORD_W-1:0]       status_word_q, serial_ctl_q, line_clock_q;
  logic                    instr_reg_load_n, branch_taken_q, carry_q;
  logic [STEP_W-1:0]       microstep_counter_q;
  logic [PRIO_OUT_W-1:0]   switch_pick_q;
  int                      err_count = 0, n_checks = 0, n, lows;

  always #25 mclk = ~mclk;

  dprs_far_model dprs_far_model_inst (.mclk, .bus_valid, .bus_word,
    .sw_pressed, .bus_data_n, .console_switch_n);

  dprs_top dprs_top_inst (.mclk, .reset_n, .bus_data_n, .a_leg, .b_leg,
    .branch_bits, .console_switch_n, .branch_code, .flag_c, .flag_n,
    .flag_v, .flag_z, .cs_wr_en, .cs_wr_addr, .cs_wr_data,
    .result_word_q, .bus_addr_q, .bus_drive_n_q, .instr_q, .b_reg_q,
    .scratch_pad_q, .status_word_q, .serial_ctl_q, .line_clock_q,
    .instr_reg_load_n, .microstep_counter_q, .cs_word_q, .switch_pick_q,
    .branch_taken_q, .carry_q);

  // ********************
  // Helpers
  // ********************
  function automatic logic [CS_W-1:0] img(input int a);
    case (a)
      0: return 40'h00007DDF01;
      1: return 40'h0000030002;
      3: return 40'h0000030903;
      default: return 40'h0000000000;
    endcase
  endfunction

  function automatic logic [7:0] pick(input logic [4:0] r);
    logic [7:0] p;
    p = '0;
    for (int i = 0; i < 5; i++) if (r[i]) p[4:0] = 5'(1 << i);
    p[5] = |r;
    p[6] = (r & (r - 5'h01)) != 5'h00;
    return p;
  endfunction

  function automatic logic brx(input logic [3:0] k, input logic [3:0] f);
    logic c, ng, v, z;
    logic [15:0] t;
    {c, ng, v, z} = f;
    t = {1'b0, c, !c, v, !v, c | z, !(c | z), ng, !ng, z | (ng ^ v),
         !(z | (ng ^ v)), ng ^ v, !(ng ^ v), z, !z, 1'b1};
    return t[k];
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wait_step(input logic [7:0] s);
    n = 0;
    lows = 0;
    while (microstep_counter_q !== s && n < 40) begin
      @(negedge mclk);
      n++;
      if (instr_reg_load_n === 1'b0) lows++;
    end
    if (n >= 40) begin
      err_count++;
      test_done();
    end
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_load_store;
    for (int a = 0; a < 256; a++) begin
      @(posedge mclk);
      cs_wr_en <= 1'b1;
      cs_wr_addr <= 8'(a);
      cs_wr_data <= img(a);
    end
    @(posedge mclk);
    cs_wr_en <= 1'b0;
  endtask

  task automatic t_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    a_leg <= 16'h1234;
    b_leg <= 16'h5A5A;
    bus_valid <= 1'b1;
    bus_word <= 16'hA5C3;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk(microstep_counter_q, 8'h00);
    chk(bus_drive_n_q, 16'hFFFF);
    @(posedge mclk);
    reset_n <= 1'b1;
  endtask

  task automatic t_alu_path;
    repeat (4) @(negedge mclk);
    chk(cs_word_q, img(0));
    chk(result_word_q, 16'h1234);
    wait_step(8'h01);
    chk(lows, 1);
    chk(instr_q, 16'h1234);
    chk(bus_addr_q, 16'h1234);
    chk(b_reg_q, 16'h1234);
    chk(scratch_pad_q, 16'h1234);
    chk(status_word_q, 16'h1234);
    chk(serial_ctl_q, 16'h1234);
    chk(line_clock_q, 16'h1234);
    chk(bus_drive_n_q, 16'hFFFF);
  endtask

  task automatic t_bus_path;
    repeat (3) @(negedge mclk);
    chk(result_word_q, 16'hA5C3);
    wait_step(8'h02);
    chk(lows, 0);
    chk(bus_addr_q, 16'hA5C3);
    chk(bus_drive_n_q, 16'h5A3C);
    chk(instr_q, 16'h1234);
  endtask

  task automatic t_branch_or;
    @(posedge mclk);
    branch_bits <= 8'h03;
    a_leg <= 16'hFFFF;
    wait_step(8'h03);
    chk(n, 6);
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk);
      bus_word <= 16'h000F << (4 * k);
      bus_valid <= (k < 4);
      repeat (3) @(negedge mclk);
      chk(result_word_q, (k < 4) ? 16'h000F << (4 * k) : 16'h0000);
    end
    chk(microstep_counter_q, 8'h03);
    chk(carry_q, 1'b1);
    @(posedge mclk);
    branch_bits <= 8'h04;
    bus_valid <= 1'b1;
    wait_step(8'h07);
    chk(microstep_counter_q, 8'h07);
  endtask

  task automatic t_encoder;
    for (int r = 0; r < 32; r++) begin
      @(posedge mclk);
      sw_pressed <= 5'(r);
      repeat (3) @(negedge mclk);
      chk(switch_pick_q, pick(5'(r)));
    end
    chk(switch_pick_q[4:0], 5'h10);
  endtask

  task automatic t_branch_dec;
    for (int k = 0; k < 16; k++) begin
      for (int f = 0; f < 16; f++) begin
        @(posedge mclk);
        branch_code <= 4'(k);
        {flag_c, flag_n, flag_v, flag_z} <= 4'(f);
        repeat (2) @(negedge mclk);
        chk(branch_taken_q, brx(4'(k), 4'(f)));
      end
    end
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (8) @(posedge mclk);
    t_load_store();
    t_reset();
    t_alu_path();
    t_bus_path();
    t_branch_or();
    t_encoder();
    t_branch_dec();
    test_done();
  end
endmodule
